//--- sim/regulator_fault_protection_tb.sv
// Purpose: Self-checking bench for the fault supervision core.
// Assumes: Short parameter counts; inputs change on the falling edge.
// Notes: Input to output takes three edges, so six cycles always settles.
`timescale 1ns/1ps
module regulator_fault_protection_tb;
    import rfp_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RST_B = 1'b0;
    logic I_ENABLE = 1'b0;
    logic [DAC_W-1:0] I_DAC_TARGET = 8'h05;
    logic [15:0] I_UV_MARGIN = 16'h0000;
    logic ramp_low = 1'b0, oc_100 = 1'b0, oc_150 = 1'b0, uv_trip = 1'b0;
    logic ov_run = 1'b0, ov_start = 1'b0, below_rel;
    rfp_cmp_t I_CMP;
    logic [DAC_W-1:0] O_DAC_CODE, last;
    logic [15:0] O_UV_MARGIN;
    logic O_OV_START_SEL, O_READY, O_FAULT_OC, O_FAULT_OV;
    rfp_gate_t O_GATE;
    int failures = 0;
    int checked = 0;
    int n;
    // The comparator levels travel together to the block.
    assign I_CMP = '{ramp_low, oc_100, oc_150, uv_trip, ov_run, ov_start, below_rel};
    always #2.5 I_CLK = ~I_CLK;
    rfp_core #(.OC_CYC(20), .SS_CYC(4), .OVR_CYC(8)) u_rfp_core (.I_CLK(I_CLK),
        .I_RST_B(I_RST_B), .I_ENABLE(I_ENABLE), .I_DAC_TARGET(I_DAC_TARGET),
        .I_UV_MARGIN(I_UV_MARGIN), .I_CMP(I_CMP), .O_DAC_CODE(O_DAC_CODE),
        .O_UV_MARGIN(O_UV_MARGIN), .O_OV_START_SEL(O_OV_START_SEL), .O_GATE(O_GATE),
        .O_READY(O_READY), .O_FAULT_OC(O_FAULT_OC), .O_FAULT_OV(O_FAULT_OV));
    rfp_stage_model u_rfp_stage_model (.i_clk(I_CLK), .i_gate(O_GATE), .o_below_rel(below_rel));

    // Compares one value and counts the result.
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task close_out;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task settle(input int k);
        repeat (k) @(negedge I_CLK);
    endtask
    // Drops enable and expects every latched fault to clear.
    task enable_cycle;
        I_ENABLE = 1'b0;
        settle(6);
        chk(O_FAULT_OC, 1'b0);
        chk(O_FAULT_OV, 1'b0);
    endtask
    // Enables and follows the soft start one step at a time up to ready.
    task start_up;
        I_ENABLE = 1'b1;
        last = '0;
        for (n = 0; n < 300 && O_READY !== 1'b1; n++) begin
            settle(1);
            if (O_DAC_CODE !== last) begin
                chk(O_DAC_CODE, last + 8'h01);
                last = O_DAC_CODE;
            end
        end
        if (n == 300) begin
            failures++;
            close_out;
        end
        chk(O_DAC_CODE, I_DAC_TARGET);
        chk(O_OV_START_SEL, 1'b0);
        chk(O_GATE.hs_en, 1'b1);
    endtask
    task sc_reset;
        chk(O_UV_MARGIN, 16'h012c);
        chk(O_OV_START_SEL, 1'b1);
        chk({O_DAC_CODE, O_GATE, O_READY, O_FAULT_OC, O_FAULT_OV}, 16'h0000);
    endtask
    // A DAC-relative trip is ignored in soft start, the fixed one is not.
    task sc_ov_soft;
        I_ENABLE = 1'b1;
        settle(6);
        ov_run = 1'b1;
        settle(4);
        chk(O_FAULT_OV, 1'b0);
        chk(O_OV_START_SEL, 1'b1);
        ov_run = 1'b0;
        ov_start = 1'b1;
        settle(5);
        chk(O_FAULT_OV, 1'b1);
        ov_start = 1'b0;
        enable_cycle;
    endtask
    // Programmed and default margins, and undervoltage dropping ready.
    task sc_margin;
        start_up;
        I_UV_MARGIN = 16'h00c8;
        uv_trip = 1'b1;
        settle(6);
        chk(O_UV_MARGIN, 16'h00c8);
        chk(O_READY, 1'b0);
        uv_trip = 1'b0;
        I_UV_MARGIN = 16'h0000;
        settle(6);
        chk(O_READY, 1'b1);
        chk(O_UV_MARGIN, 16'h012c);
        enable_cycle;
    endtask
    // A short over-current is forgiven, a long one latches until enable cycles.
    task sc_oc;
        start_up;
        oc_100 = 1'b1;
        settle(15);
        oc_100 = 1'b0;
        settle(30);
        chk(O_FAULT_OC, 1'b0);
        oc_100 = 1'b1;
        settle(15);
        chk(O_FAULT_OC, 1'b0);
        settle(15);
        chk(O_FAULT_OC, 1'b1);
        oc_100 = 1'b0;
        settle(20);
        chk({O_FAULT_OC, O_GATE.hs_en}, 2'b10);
        enable_cycle;
        start_up;
        oc_150 = 1'b1;
        settle(5);
        chk({O_FAULT_OC, O_GATE.hs_en}, 2'b10);
        oc_150 = 1'b0;
        enable_cycle;
    endtask
    // Ramp supply low while enabled stops switching.
    task sc_ramp;
        start_up;
        ramp_low = 1'b1;
        settle(6);
        chk({O_GATE.hs_en, O_READY}, 2'b00);
        I_ENABLE = 1'b0;
        settle(6);
        ramp_low = 1'b0;
    endtask
    // Overvoltage in run: ready low, low side on, slow ramp down, latched.
    task sc_ov_run;
        start_up;
        ov_run = 1'b1;
        settle(5);
        ov_run = 1'b0;
        chk({O_FAULT_OV, O_READY}, 2'b10);
        chk(O_GATE, 2'b01);
        last = O_DAC_CODE;
        settle(20);
        chk(O_DAC_CODE < last, 1'b1);
        settle(250);
        chk(O_GATE, 2'b00);
        chk(O_FAULT_OV, 1'b1);
        enable_cycle;
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        settle(3);
        sc_reset;
        settle(3);
        I_RST_B = 1'b1;
        settle(2);
        sc_ov_soft;
        sc_margin;
        sc_oc;
        sc_ramp;
        sc_ov_run;
        close_out;
    end
endmodule

//--- sim/rfp_stage_model.sv
// Purpose: Behavioural power stage that turns gate commands into an output level.
// Assumes: The high side charges and the low side alone discharges slowly.
// Notes: Only the release comparator is modelled; other levels come from the bench.
`timescale 1ns/1ps
module rfp_stage_model
    import rfp_pkg::*;
(
    input wire logic i_clk, // System clock.
    input wire rfp_gate_t i_gate, // Gate drive commands from the block.
    output logic o_below_rel // High while the output is under the release level.
);
    int mv = 0;
    // The output voltage in millivolts follows the gate commands.
    always @(posedge i_clk) begin
        if (i_gate.hs_en) begin
            mv <= (mv > 1180) ? 1200 : mv + 20;
        end else if (i_gate.ls_en) begin
            mv <= (mv < 5) ? 0 : mv - 5;
        end
    end
    // The release comparator trips below its fixed level.
    assign o_below_rel = (mv < int'(OV_RELEASE_MV));
endmodule

//--- src/rfp_core.sv
// Purpose: Fault supervision and soft start sequencing for a buck controller.
// Assumes: Comparator levels are asynchronous and pass two flops first.
// Notes: Over-current and overvoltage shutdowns latch until enable is cycled; supply cycling is power-on reset.
`timescale 1ns/1ps
module rfp_core
    import rfp_pkg::*;
#(
    parameter int unsigned OC_CYC = OC_LATCH_CYC,
    parameter int unsigned SS_CYC = SS_STEP_CYC,
    parameter int unsigned OVR_CYC = OVR_STEP_CYC
) (
    input wire logic I_CLK, // 200 MHz system clock.
    input wire logic I_RST_B, // Asynchronous power-on reset, active low.
    input wire logic I_ENABLE, // Controller enable pin.
    input wire logic [DAC_W-1:0] I_DAC_TARGET, // Target reference code.
    input wire logic [15:0] I_UV_MARGIN, // Ready-low limit setting in mV.
    input wire rfp_cmp_t I_CMP, // Raw comparator levels.
    output logic [DAC_W-1:0] O_DAC_CODE, // Reference DAC code.
    output logic [15:0] O_UV_MARGIN, // Margin applied to the UV comparator.
    output logic O_OV_START_SEL, // High selects the fixed start-up OV threshold.
    output rfp_gate_t O_GATE, // Gate drive commands.
    output logic O_READY, // Regulator ready flag.
    output logic O_FAULT_OC, // Over-current shutdown latched.
    output logic O_FAULT_OV // Overvoltage protection engaged.
);
    localparam int unsigned OCW = $clog2(OC_CYC + 1);
    localparam logic [OCW-1:0] OC_LAST = OCW'(OC_CYC - 1);

    rfp_cmp_t cmp_s1_reg;
    rfp_cmp_t cmp_reg;
    logic en_s1_reg;
    logic en_reg;
    rfp_state_t state_reg;
    rfp_state_t state_next;
    logic [OCW-1:0] oc_cnt_reg;
    logic ss_tick;
    logic ovr_tick;

    // Two-flop synchronisers for every asynchronous level.
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cmp_s1_reg <= '0;
            cmp_reg <= '0;
            en_s1_reg <= 1'b0;
            en_reg <= 1'b0;
        end else begin
            cmp_s1_reg <= I_CMP;
            cmp_reg <= cmp_s1_reg;
            en_s1_reg <= I_ENABLE;
            en_reg <= en_s1_reg;
        end
    end

    // Decoded conditions from the state, the synchronised inputs, the latch-off timer and the DAC code.
    wire active = (state_reg == RFP_SOFT) || (state_reg == RFP_RUN);
    wire ramp_fault = en_reg && cmp_reg.ramp_low;
    wire oc_timeout = cmp_reg.oc_100 && (oc_cnt_reg == OC_LAST);
    wire oc_fault = active && (cmp_reg.oc_150 || oc_timeout);
    wire ov_thr = (state_reg == RFP_SOFT) ? cmp_reg.ov_start : cmp_reg.ov_run;
    wire ov_fault = active && ov_thr;
    wire ss_done = (O_DAC_CODE >= I_DAC_TARGET);

    // Latch-off timer runs only while the over-current level persists.
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            oc_cnt_reg <= '0;
        end else if (!active || !cmp_reg.oc_100) begin
            oc_cnt_reg <= '0;
        end else if (!oc_timeout) begin
            oc_cnt_reg <= oc_cnt_reg + 1'b1;
        end
    end

    // Sequencer; latched faults leave only when enable drops.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RFP_OFF: begin
                if (en_reg && !ramp_fault) begin
                    state_next = RFP_SOFT;
                end
            end
            RFP_SOFT, RFP_RUN: begin
                if (!en_reg || ramp_fault) begin
                    state_next = RFP_OFF;
                end else if (ov_fault) begin
                    state_next = RFP_OV_LATCH;
                end else if (oc_fault) begin
                    state_next = RFP_OC_LATCH;
                end else if (state_reg == RFP_SOFT && ss_done) begin
                    state_next = RFP_RUN;
                end
            end
            RFP_OC_LATCH, RFP_OV_LATCH: begin
                if (!en_reg) begin
                    state_next = RFP_OFF;
                end
            end
        endcase
    end

    // Step dividers for soft start up and overvoltage ramp down.
    rfp_step_timer #(.PERIOD(SS_CYC)) u_ss_timer (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_run(state_reg == RFP_SOFT),
        .o_tick(ss_tick)
    );
    rfp_step_timer #(.PERIOD(OVR_CYC)) u_ovr_timer (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_run(state_reg == RFP_OV_LATCH),
        .o_tick(ovr_tick)
    );

    // DAC code next value.
    wire dac_up = (state_reg == RFP_SOFT) && ss_tick && !ss_done;
    wire dac_dn = (state_reg == RFP_OV_LATCH) && ovr_tick && (O_DAC_CODE != '0);
    wire [DAC_W-1:0] dac_next = (state_reg == RFP_OFF || state_reg == RFP_OC_LATCH) ? '0 :
                                dac_up ? O_DAC_CODE + 1'b1 :
                                dac_dn ? O_DAC_CODE - 1'b1 : O_DAC_CODE;

    // Low side holds on while in overvoltage until the output is low enough.
    wire in_ov = (state_next == RFP_OV_LATCH);
    wire ls_next = in_ov && !cmp_reg.out_below_rel;
    wire hs_next = (state_next == RFP_SOFT) || (state_next == RFP_RUN);
    wire rdy_next = (state_next == RFP_RUN) && !cmp_reg.uv_trip;

    // Registered state and outputs.
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg <= RFP_OFF;
            O_DAC_CODE <= '0;
            O_UV_MARGIN <= UV_MARGIN_DEF;
            O_OV_START_SEL <= 1'b1;
            O_GATE <= '0;
            O_READY <= 1'b0;
            O_FAULT_OC <= 1'b0;
            O_FAULT_OV <= 1'b0;
        end else begin
            state_reg <= state_next;
            O_DAC_CODE <= dac_next;
            O_UV_MARGIN <= (I_UV_MARGIN == '0) ? UV_MARGIN_DEF : I_UV_MARGIN;
            O_OV_START_SEL <= (state_next != RFP_RUN);
            O_GATE <= '{hs_en: hs_next, ls_en: ls_next};
            O_READY <= rdy_next;
            O_FAULT_OC <= (state_next == RFP_OC_LATCH);
            O_FAULT_OV <= in_ov;
        end
    end

    // Assertions.
    oc_150_trip_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && en_reg && !ramp_fault && !ov_fault && cmp_reg.oc_150)
        |=> (state_reg == RFP_OC_LATCH) ##1 !O_GATE.hs_en)
        else $error("150 percent over-current did not shut down at once");
    oc_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_OC_LATCH && en_reg) |=> (state_reg == RFP_OC_LATCH))
        else $error("Over-current latch released while enabled");
    ov_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_OV_LATCH && en_reg) |=> (state_reg == RFP_OV_LATCH) && O_FAULT_OV)
        else $error("Overvoltage state released while enabled");
    ov_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_FAULT_OV |-> !O_GATE.hs_en)
        else $error("High side on during overvoltage");
    ov_ready_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_FAULT_OV |-> !O_READY)
        else $error("Ready high during overvoltage");
    oc_timer_clr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && !cmp_reg.oc_100) |=> (oc_cnt_reg == '0))
        else $error("Latch-off timer not cleared");
    ramp_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (!en_reg && cmp_reg.ramp_low && state_reg == RFP_OFF) |=> !O_FAULT_OC && !O_FAULT_OV)
        else $error("Ramp supply fault acted while disabled");
    ss_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_SOFT && state_next == RFP_SOFT && !ss_tick)
        |=> $stable(O_DAC_CODE))
        else $error("DAC code moved between soft start steps");
    start_thr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_SOFT) |-> O_OV_START_SEL)
        else $error("Start-up OV threshold not selected");

    // Each soft start tick raises the code by exactly one step.
    soft_dac_up_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_SOFT && ss_tick && !ss_done) |=> (O_DAC_CODE == $past(O_DAC_CODE) + 1'b1))
        else $error("Soft start step did not raise the code by one");

    // The over-current latch parks the reference at zero.
    oc_dac_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_OC_LATCH) |=> (O_DAC_CODE == '0))
        else $error("DAC code not zero in over-current latch");

    // Both gates stay off while the over-current fault is latched.
    oc_gate_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_FAULT_OC |-> (O_GATE == '0))
        else $error("Gate drive on during over-current latch");

    // Ready cannot be shown while the over-current fault stands.
    oc_ready_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_FAULT_OC |-> !O_READY)
        else $error("Ready high during over-current latch");

    // The latch-off timer advances one count per cycle of fault.
    oc_timer_run_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && cmp_reg.oc_100 && !oc_timeout) |=> (oc_cnt_reg == $past(oc_cnt_reg) + 1'b1))
        else $error("Latch-off timer did not advance");

    // An expired latch-off timer shuts the regulator down.
    oc_timeout_trip_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && en_reg && !ramp_fault && !ov_fault && oc_timeout) |=> (state_reg == RFP_OC_LATCH))
        else $error("Expired latch-off timer did not shut down");

    // Without a qualified fault the over-current latch is never entered.
    oc_no_early_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && !oc_fault) |=> (state_reg != RFP_OC_LATCH))
        else $error("Over-current latch entered without a fault");

    // An overvoltage while switching engages the protective state.
    ov_trip_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && en_reg && !ramp_fault && ov_fault) |=> (state_reg == RFP_OV_LATCH))
        else $error("Overvoltage did not engage protection");

    // The low side stays on while the output is above the release level.
    ov_ls_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_next == RFP_OV_LATCH && !cmp_reg.out_below_rel) |=> O_GATE.ls_en)
        else $error("Low side off above the release level");

    // The low side lets go once the output is under the release level.
    ov_ls_release_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_next == RFP_OV_LATCH && cmp_reg.out_below_rel) |=> !O_GATE.ls_en)
        else $error("Low side still on below the release level");

    // Each ramp-down tick lowers the code by one step.
    ov_ramp_dn_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_OV_LATCH && ovr_tick && O_DAC_CODE != '0)
        |=> (O_DAC_CODE == $past(O_DAC_CODE) - 1'b1))
        else $error("Overvoltage ramp-down step missing");

    // Between ramp-down ticks the code holds, so the descent is slow.
    ov_dac_slow_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_OV_LATCH && !ovr_tick) |=> $stable(O_DAC_CODE))
        else $error("DAC code moved between ramp-down steps");

    // The low side alone is only commanded by overvoltage protection.
    ls_only_ov_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_GATE.ls_en |-> O_FAULT_OV)
        else $error("Low side on outside overvoltage");

    // Ready is only shown in normal operation.
    ready_run_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_READY |-> (state_reg == RFP_RUN))
        else $error("Ready high outside normal operation");

    // An undervoltage trip pulls ready low on the next edge.
    uv_ready_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        cmp_reg.uv_trip |=> !O_READY)
        else $error("Ready high during undervoltage");

    // A programmed margin is passed on to the comparator.
    margin_apply_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (I_UV_MARGIN != '0) |=> (O_UV_MARGIN == $past(I_UV_MARGIN)))
        else $error("Programmed margin not applied");

    // An unprogrammed margin falls back to the default.
    margin_def_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (I_UV_MARGIN == '0) |=> (O_UV_MARGIN == UV_MARGIN_DEF))
        else $error("Default margin not applied");

    // A low ramp supply while enabled stops switching.
    ramp_stop_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (active && ramp_fault) |=> (state_reg == RFP_OFF))
        else $error("Ramp supply fault did not stop switching");

    // Normal operation uses the DAC-relative threshold.
    run_thr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_RUN) |-> !O_OV_START_SEL)
        else $error("Fixed OV threshold kept in normal operation");

    // Reaching the target ends soft start.
    ss_to_run_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_SOFT && en_reg && !ramp_fault && !ov_fault && !oc_fault && ss_done)
        |=> (state_reg == RFP_RUN))
        else $error("Soft start did not end at the target");

    // Dropping enable releases the overvoltage state.
    latch_exit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (state_reg == RFP_OV_LATCH && !en_reg) |=> (state_reg == RFP_OFF))
        else $error("Overvoltage state kept after enable dropped");
endmodule

//--- src/rfp_pkg.sv
// Purpose: Shared constants and types for the regulator fault protection block.
// Assumes: 200 MHz system clock; analog comparisons arrive as digital levels.
// Notes: Times are kept in their printed units and converted to cycles here.
package rfp_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned OC_LATCH_US = 50;
    localparam int unsigned OC_LATCH_CYC = OC_LATCH_US * CLK_MHZ;
    localparam int unsigned SS_STEP_NS = 1000;
    localparam int unsigned SS_STEP_CYC = (SS_STEP_NS * CLK_MHZ) / 1000;
    localparam int unsigned OVR_STEP_NS = 8000;
    localparam int unsigned OVR_STEP_CYC = (OVR_STEP_NS * CLK_MHZ) / 1000;
    localparam int unsigned DAC_W = 8;
    localparam int unsigned UV_MARGIN_MV = 300;
    localparam int unsigned OV_MARGIN_MV = 400;
    localparam int unsigned OV_START_MV = 2500;
    localparam int unsigned OV_RELEASE_MV = 100;
    localparam int unsigned RAMP_LOCKOUT_MV = 3200;
    localparam logic [15:0] UV_MARGIN_DEF = 16'h012c;

    typedef enum {
        RFP_OFF,
        RFP_SOFT,
        RFP_RUN,
        RFP_OC_LATCH,
        RFP_OV_LATCH
    } rfp_state_t;

    // Raw comparator levels, all from the analog domain.
    typedef struct packed {
        logic ramp_low;
        logic oc_100;
        logic oc_150;
        logic uv_trip;
        logic ov_run;
        logic ov_start;
        logic out_below_rel;
    } rfp_cmp_t;

    // Gate drive commands toward the internal driver.
    typedef struct packed {
        logic hs_en;
        logic ls_en;
    } rfp_gate_t;
endpackage

//--- src/rfp_step_timer.sv
// Purpose: Divider that emits a one-cycle enable every PERIOD cycles.
// Assumes: Synchronous clear restarts the count.
// Notes: Used for the soft start and overvoltage ramp-down steps.
`timescale 1ns/1ps
module rfp_step_timer #(
    parameter int unsigned PERIOD = 200
) (
    input wire logic i_clk, // System clock.
    input wire logic i_rst_b, // Asynchronous reset, active low.
    input wire logic i_run, // Count while high, clear while low.
    output logic o_tick // One-cycle pulse each period.
);
    localparam int unsigned CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_reg;
    wire at_last = (cnt_reg == LAST);

    // Count that wraps at the period boundary and clears while i_run is low.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_reg <= (!i_run || at_last) ? '0 : cnt_reg + 1'b1;
            o_tick <= i_run && at_last;
        end
    end
endmodule
